// >>> core/rsd_cfg.svh
// constants for the reset, strap and debug event pin block
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define RSD_OFS_STATUS   12'h000
`define RSD_OFS_STRAP    12'h004
`define RSD_OFS_EVDIR    12'h008
`define RSD_OFS_EVOUT    12'h00c
`define RSD_OFS_EVSEL    12'h010
`define RSD_OFS_EVIN     12'h014
`define RSD_OFS_CONTROL  12'h018
`define RSD_OFS_BUSINFO  12'h01c
// ----------------------------------------------------------------
// reset values and field positions
// ----------------------------------------------------------------
`define RSD_EVDIR_RST    7'h00
`define RSD_EVSEL_RST    7'h00
`define RSD_CTRL_RST     4'h0
`define RSD_CTRL_CLKDIV  0
`define RSD_CTRL_MULTI   1
`define RSD_CTRL_NARROW  2
`define RSD_BUSDEF_RST   3'h0
// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define RSD_RST_STRETCH_NS  100
`define RSD_CLK_NS          20
`define RSD_RST_STRETCH_CYC ((`RSD_RST_STRETCH_NS + `RSD_CLK_NS - 1) / `RSD_CLK_NS)
`endif

// >>> core/rsd_pkg.sv
// types for the reset, strap and debug event pin block
package rsd_pkg;
    // reset state of the device, lowest precedence first
    typedef enum logic [1:0] {RSD_RUN, RSD_SOFT, RSD_HARD, RSD_POR} rsd_state_e;
    // straps captured at power-on release
    typedef struct packed {
        logic       host_port_boot;   // host port boot selected
        logic       debug_entry;      // enter debug mode after release
        logic [1:0] boot_mode;        // boot mode choice
        logic [2:0] clock_mode;       // clock circuit mode
    } rsd_strap_s;
    // seven event pins: bits 0..5 address channels, bit 6 data event
    typedef logic [6:0] rsd_ev_t;
endpackage : rsd_pkg

// >>> core/rsd_top.sv
// reset sequencing, strap capture and debug event pin control
//
// How it works
// - por input holds power-on reset state
// - hard reset line enters hard reset
// - soft reset line enters soft reset
// - host strap enables host port, 32-bit bus
// - debug strap at release enters debug mode
// - boot mode strap captured at release
// - event pins default input, software selects output
// - pin0: request/enable/event in, channel0 out
// - pin1: acknowledge or channel1 out
// - pin2: channel2, counter enable in
// - pin3 out: receive register read
// - pin4 out: transmit register written
// - pin5: channel5 enable in, detect out
// - data pin: data channel enable/detect
// - clock mode straps select clock mode
// - multi-master mode drives bank selects
// - transfer codes describe own transactions
// - bus clock driven on output pin
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ns
`include "rsd_cfg.svh"
module rsd_top
    import rsd_pkg::*;
#(
    parameter int unsigned STRETCH = `RSD_RST_STRETCH_CYC   // reset stretch cycles
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // reset pins
    input  wire logic        power_on_reset_n,
    input  wire logic        hard_reset_n_in,
    output logic             hard_reset_n_out,
    output logic             hard_reset_n_oe,
    input  wire logic        soft_reset_n_in,
    output logic             soft_reset_n_out,
    output logic             soft_reset_n_oe,
    input  wire logic        reset_cfg_select,
    // straps
    input  wire logic        host_port_boot_strap,
    input  wire logic        debug_entry_strap,
    input  wire logic [1:0]  boot_mode_strap,
    input  wire logic        clock_mode_strap_1,
    input  wire logic        clock_mode_strap_2,
    input  wire logic        clock_mode_strap_3,
    // event pins, bit 6 is the data event pin
    input  wire rsd_ev_t     event_pin_in,
    output rsd_ev_t          event_pin_out,
    output rsd_ev_t          event_pin_oe,
    // internal debug sources
    input  wire logic [5:0]  addr_detect,
    input  wire logic        data_detect,
    input  wire logic        debug_ack,
    input  wire logic        rcv_reg_read,
    input  wire logic        xmt_reg_write,
    output logic             debug_request,
    output logic [5:0]       addr_chan_enable,
    output logic             data_chan_enable,
    output logic             event_gen,
    output logic             event_counter_enable,
    // own bus transaction info
    input  wire logic        own_xfer_valid,
    input  wire logic [2:0]  own_xfer_code,
    output logic             xfer_code_0,
    output logic             xfer_code_1,
    output logic             xfer_code_2,
    output logic             sdram_bank_sel_0,
    output logic             sdram_bank_sel_1,
    output logic             sdram_bank_sel_2,
    output logic             bank_pin_oe,
    input  wire logic [2:0]  own_bank,
    // clocks and resets to the core
    input  wire logic        ref_clock_in,
    input  wire logic        delay_loop_feedback_in,
    output logic             bus_clock_out,
    output rsd_state_e       reset_state,
    output rsd_strap_s       strap_value,
    output logic             host_port_enable,
    output logic             bus_32bit,
    output logic             debug_mode_entry,
    output logic [1:0]       boot_select,
    output logic [2:0]       clock_mode
);
    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    localparam int NS = 19;                 // synchronised inputs
    logic [NS-1:0] sync_raw;                // raw pins
    logic [NS-1:0] sync1_q;                 // first stage, read by stage two only
    logic [NS-1:0] sync2_q;                 // second stage, safe to use
    logic [NS-1:0] sync1_d;
    logic [NS-1:0] sync2_d;
    assign sync_raw = {delay_loop_feedback_in, reset_cfg_select, event_pin_in, clock_mode_strap_3,
                       clock_mode_strap_2, clock_mode_strap_1, boot_mode_strap, debug_entry_strap,
                       host_port_boot_strap, soft_reset_n_in, hard_reset_n_in, power_on_reset_n};

    // two-flop chain, pins come from outside the clock domain
    always_comb
    begin
        sync1_d = sync_raw;
        sync2_d = sync1_q;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 19'h00007;           // resets idle high
            sync2_q <= 19'h00007;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    logic    por_n_s;                       // synced power-on reset
    logic    hard_n_s;                      // synced hard reset
    logic    soft_n_s;                      // synced soft reset
    rsd_strap_s strap_s;                    // synced straps
    rsd_ev_t ev_in_s;                       // synced event pins
    assign por_n_s  = sync2_q[0];
    assign hard_n_s = sync2_q[1];
    assign soft_n_s = sync2_q[2];
    assign strap_s  = {sync2_q[3], sync2_q[4], sync2_q[6:5], sync2_q[9:7]};
    assign ev_in_s  = sync2_q[16:10];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    rsd_state_e state_q, state_d;           // reset state
    logic [7:0] cnt_q, cnt_d;               // stretch counter
    rsd_strap_s strap_q, strap_d;           // captured straps
    logic       cfg_done_q, cfg_done_d;     // host wrote config word
    rsd_ev_t    evdir_q, evdir_d;           // 1 = output
    rsd_ev_t    evsel_q, evsel_d;           // alternate function select
    rsd_ev_t    evout_q, evout_d;           // registered pin drive
    logic [3:0] ctrl_q, ctrl_d;             // clock div, multi-master, narrow
    logic       hrst_drv_q, hrst_drv_d;     // software hard reset request
    logic       srst_drv_q, srst_drv_d;     // software soft reset request
    logic [2:0] xfer_q, xfer_d;             // transfer code / bank pins
    logic       bclk_q, bclk_d;             // bus clock divider
    logic [31:0] rdata_q, rdata_d;          // read data
    logic       err_d;

    wire wr_acc = psel & penable & pwrite;   // write access phase
    wire wr_set = psel & ~penable & pwrite;  // write setup, error ready for access
    wire rd_set = psel & ~penable & ~pwrite; // read setup, data ready for access

    // next-state logic
    always_comb
    begin
        state_d    = state_q;
        cnt_d      = cnt_q;
        strap_d    = strap_q;
        cfg_done_d = cfg_done_q;
        evdir_d    = evdir_q;
        evsel_d    = evsel_q;
        ctrl_d     = ctrl_q;
        hrst_drv_d = 1'b0;
        srst_drv_d = 1'b0;
        rdata_d    = rdata_q;
        err_d      = 1'b0;
        // reset precedence, por first
        if (!por_n_s)
        begin
            state_d    = RSD_POR;
            cnt_d      = 8'(STRETCH);
            strap_d    = strap_s;                       // sampled until release
            cfg_done_d = 1'b0;
            evdir_d    = `RSD_EVDIR_RST;
            evsel_d    = `RSD_EVSEL_RST;
            ctrl_d     = `RSD_CTRL_RST;
        end
        else if (!hard_n_s)
        begin
            state_d = RSD_HARD;
            cnt_d   = 8'(STRETCH);
        end
        else if (!soft_n_s)
        begin
            if (state_q != RSD_HARD && state_q != RSD_POR)
                state_d = RSD_SOFT;
            cnt_d = 8'(STRETCH);
        end
        else if (cnt_q != 8'h00)
            cnt_d = cnt_q - 8'h01;                      // stretch after release
        else
        begin
            case (state_q)
                RSD_POR:
                    // host boot waits for the config word
                    if (!strap_q.host_port_boot || cfg_done_q)
                        state_d = RSD_RUN;
                RSD_HARD, RSD_SOFT:
                    state_d = RSD_RUN;
                default:
                    state_d = RSD_RUN;
            endcase
        end
        // register writes take effect at the access edge
        if (wr_acc)
        begin
            if (paddr == `RSD_OFS_EVDIR)
                evdir_d = pwdata[6:0];
            else if (paddr == `RSD_OFS_EVSEL)
                evsel_d = pwdata[6:0];
            else if (paddr == `RSD_OFS_CONTROL)
            begin
                ctrl_d     = pwdata[3:0];
                cfg_done_d = cfg_done_q | pwdata[8];    // config word written
                hrst_drv_d = pwdata[9];
                srst_drv_d = pwdata[10];
            end
        end
        // write errors flagged in setup so pslverr stands in the access phase
        if (wr_set && paddr != `RSD_OFS_EVDIR && paddr != `RSD_OFS_EVSEL && paddr != `RSD_OFS_CONTROL
            && paddr != `RSD_OFS_EVOUT)
            err_d = 1'b1;
        // read mux, loaded in setup so prdata stands in the access phase
        if (rd_set)
        begin
            if (paddr == `RSD_OFS_STATUS)
                rdata_d = {26'h0, cfg_done_q, debug_mode_entry, 2'(state_q), hard_n_s, soft_n_s};
            else if (paddr == `RSD_OFS_STRAP)
                rdata_d = {25'h0, strap_q};
            else if (paddr == `RSD_OFS_EVDIR)
                rdata_d = {25'h0, evdir_q};
            else if (paddr == `RSD_OFS_EVOUT)
                rdata_d = {25'h0, evout_q};
            else if (paddr == `RSD_OFS_EVSEL)
                rdata_d = {25'h0, evsel_q};
            else if (paddr == `RSD_OFS_EVIN)
                rdata_d = {25'h0, ev_in_s};
            else if (paddr == `RSD_OFS_CONTROL)
                rdata_d = {23'h0, cfg_done_q, 4'h0, ctrl_q};
            else if (paddr == `RSD_OFS_BUSINFO)
                rdata_d = {29'h0, xfer_q};
            else
            begin
                rdata_d = 32'h0;
                err_d   = 1'b1;                         // unmapped
            end
        end
    end

    // ----------------------------------------------------------------
    // event pin output functions
    // ----------------------------------------------------------------
    always_comb
    begin
        evout_d    = 7'h00;
        evout_d[0] = addr_detect[0];
        evout_d[1] = evsel_q[1] ? debug_ack : addr_detect[1];
        evout_d[2] = addr_detect[2];
        evout_d[3] = rcv_reg_read;
        evout_d[4] = xmt_reg_write;
        evout_d[5] = addr_detect[5];
        evout_d[6] = data_detect;
        // transfer code or bank select on shared pins
        if (ctrl_q[`RSD_CTRL_MULTI])
            xfer_d = own_bank;
        else
            xfer_d = own_xfer_valid ? own_xfer_code : `RSD_BUSDEF_RST;
        bclk_d = ctrl_q[`RSD_CTRL_CLKDIV] ? ~bclk_q : 1'b0;
    end

    // state registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q    <= RSD_POR;
            cnt_q      <= 8'h00;
            strap_q    <= '0;
            cfg_done_q <= 1'b0;
            evdir_q    <= `RSD_EVDIR_RST;
            evsel_q    <= `RSD_EVSEL_RST;
            evout_q    <= 7'h00;
            ctrl_q     <= `RSD_CTRL_RST;
            hrst_drv_q <= 1'b0;
            srst_drv_q <= 1'b0;
            xfer_q     <= 3'h0;
            bclk_q     <= 1'b0;
            rdata_q    <= 32'h0;
            pslverr    <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            strap_q    <= strap_d;
            cfg_done_q <= cfg_done_d;
            evdir_q    <= evdir_d;
            evsel_q    <= evsel_d;
            evout_q    <= evout_d;
            ctrl_q     <= ctrl_d;
            hrst_drv_q <= hrst_drv_d;
            srst_drv_q <= srst_drv_d;
            xfer_q     <= xfer_d;
            bclk_q     <= bclk_d;
            rdata_q    <= rdata_d;
            pslverr    <= err_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // zero-wait apb, read data registered at setup
    assign pready = 1'b1;
    assign prdata = rdata_q;
    // open-drain: drive low only, enable while pulling
    assign hard_reset_n_out = 1'b0;
    assign hard_reset_n_oe  = hrst_drv_q;
    assign soft_reset_n_out = 1'b0;
    assign soft_reset_n_oe  = srst_drv_q;
    // pins stay inputs while in power-on reset
    assign event_pin_oe  = (state_q == RSD_POR) ? 7'h00 : evdir_q;
    assign event_pin_out = evout_q;
    // input functions, gated by direction
    assign debug_request        = ~evdir_q[0] & ~evsel_q[0] & ev_in_s[0];
    assign addr_chan_enable     = ~evdir_q[5:0] & ev_in_s[5:0];
    assign data_chan_enable     = ~evdir_q[6] & ev_in_s[6];
    assign event_gen            = |(~evdir_q[4:0] & evsel_q[4:0] & ev_in_s[4:0]);
    assign event_counter_enable = ~evdir_q[2] & evsel_q[2] & ev_in_s[2];
    assign {xfer_code_2, xfer_code_1, xfer_code_0}                = xfer_q;
    assign {sdram_bank_sel_2, sdram_bank_sel_1, sdram_bank_sel_0} = xfer_q;
    assign bank_pin_oe     = (state_q == RSD_RUN);
    assign bus_clock_out   = bclk_q;
    assign reset_state     = state_q;
    assign strap_value     = strap_q;
    assign host_port_enable = strap_q.host_port_boot;
    assign bus_32bit        = strap_q.host_port_boot | ctrl_q[`RSD_CTRL_NARROW];
    assign debug_mode_entry = strap_q.debug_entry;
    assign boot_select      = strap_q.boot_mode;
    assign clock_mode       = strap_q.clock_mode;
endmodule : rsd_top

// >>> sim/rsd_properties.sv
// concurrent checks on the reset, strap and event pin block
`timescale 1ns/1ns
module rsd_props
    import rsd_pkg::*;
(
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       power_on_reset_n,
    input wire logic       hard_reset_n_in,
    input wire logic       soft_reset_n_in,
    input wire logic [5:0] addr_detect,
    input wire logic       data_detect,
    input wire logic       rcv_reg_read,
    input wire logic       xmt_reg_write,
    input wire rsd_ev_t    event_pin_out,
    input wire rsd_ev_t    event_pin_oe,
    input wire rsd_state_e reset_state,
    input wire rsd_strap_s strap_value,
    input wire logic [2:0] clock_mode,
    input wire logic [1:0] boot_select,
    input wire logic       bank_pin_oe,
    input wire logic       bus_clock_out
);
    // ----------------------------------------------------------------
    // one clock domain, so one default clocking
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // four edges: two-flop sync, state register, then the sampled value
    property p_por; !power_on_reset_n [*4] |-> reset_state == RSD_POR; endproperty
    a_por: assert property (p_por) else $error("por not held");
    property p_hard; !hard_reset_n_in [*4] |-> reset_state inside {RSD_HARD, RSD_POR}; endproperty
    a_hard: assert property (p_hard) else $error("hard reset missed");
    property p_soft; !soft_reset_n_in [*4] |-> reset_state != RSD_RUN; endproperty
    a_soft: assert property (p_soft) else $error("soft reset missed");
    property p_dir; reset_state == RSD_POR |-> event_pin_oe == 7'h00; endproperty
    a_dir: assert property (p_dir) else $error("event pin driven in por");
    property p_ev0; reset_state == RSD_RUN && addr_detect[0] |=> event_pin_out[0]; endproperty
    a_ev0: assert property (p_ev0) else $error("pin0 detect lost");
    property p_ev3; reset_state == RSD_RUN && $rose(rcv_reg_read) |=> event_pin_out[3]; endproperty
    a_ev3: assert property (p_ev3) else $error("pin3 read flag lost");
    property p_ev4; reset_state == RSD_RUN && xmt_reg_write ##1 1'b1 |-> event_pin_out[4]; endproperty
    a_ev4: assert property (p_ev4) else $error("pin4 write flag lost");
    property p_evd; reset_state == RSD_RUN && data_detect |=> event_pin_out[6]; endproperty
    a_evd: assert property (p_evd) else $error("data pin detect lost");
    property p_clk; bus_clock_out |=> !bus_clock_out; endproperty
    a_clk: assert property (p_clk) else $error("bus clock stuck high");
    property p_bank; reset_state == RSD_RUN |-> bank_pin_oe; endproperty
    a_bank: assert property (p_bank) else $error("bank pins not driven");
    property p_mode;
        reset_state == RSD_RUN |-> clock_mode == strap_value.clock_mode && boot_select == strap_value.boot_mode;
    endproperty
    a_mode: assert property (p_mode) else $error("strap outputs differ");
    // main scenarios reached
    c_hard: cover property (reset_state == RSD_HARD);
    c_soft: cover property (reset_state == RSD_SOFT);
    c_clk: cover property ($rose(bus_clock_out));
endmodule : rsd_props

bind rsd_top rsd_props u_props (.*);

// >>> sim/rsd_board.sv
// board reset logic and debug equipment on the far side of the pins
`timescale 1ns/1ns
module rsd_board
    import rsd_pkg::*;
(
    input  wire logic    por_req,   // board holds power-on reset
    input  wire logic    hard_req,  // board pulls the hard line
    input  wire logic    soft_req,  // board pulls the soft line
    input  wire logic    hard_out,
    input  wire logic    hard_oe,
    input  wire logic    soft_out,
    input  wire logic    soft_oe,
    input  wire rsd_ev_t ev_ext,    // debug equipment level
    input  wire rsd_ev_t ev_out,
    input  wire rsd_ev_t ev_oe,
    output logic         por_n,
    output logic         hard_n,
    output logic         soft_n,
    output rsd_ev_t      ev_in
);
    // power-on reset is a plain driven level
    assign por_n = ~por_req;
    // open drain with pull-up: any party pulling low wins
    assign hard_n = ~(hard_req | (hard_oe & ~hard_out));
    assign soft_n = ~(soft_req | (soft_oe & ~soft_out));
    // equipment drives a pin only while the device listens, so no fight
    assign ev_in = (ev_oe & ev_out) | (~ev_oe & ev_ext);
endmodule : rsd_board

// >>> sim/tb.sv
// self-checking bench for the reset, strap and event pin block
`timescale 1ns/1ns
`include "rsd_cfg.svh"
module tb
    import rsd_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic power_on_reset_n, hard_reset_n_in, hard_reset_n_out, hard_reset_n_oe, reset_cfg_select;
    logic soft_reset_n_in, soft_reset_n_out, soft_reset_n_oe, host_port_boot_strap, debug_entry_strap;
    logic clock_mode_strap_1, clock_mode_strap_2, clock_mode_strap_3, por_req, hard_req, soft_req;
    logic [1:0] boot_mode_strap, boot_select;
    rsd_ev_t event_pin_in, event_pin_out, event_pin_oe, ev_ext, src;
    logic [5:0] addr_detect, addr_chan_enable;
    logic data_detect, debug_ack, rcv_reg_read, xmt_reg_write, debug_request, data_chan_enable;
    logic event_gen, event_counter_enable, own_xfer_valid, xfer_code_0, xfer_code_1, xfer_code_2;
    logic sdram_bank_sel_0, sdram_bank_sel_1, sdram_bank_sel_2, bank_pin_oe, ref_clock_in;
    logic delay_loop_feedback_in, bus_clock_out, host_port_enable, bus_32bit, debug_mode_entry, b;
    logic [2:0] own_xfer_code, own_bank, clock_mode, ckm;
    rsd_state_e reset_state;
    rsd_strap_s strap_value;
    int n_fail, cmp_count, cyc;
    // one source vector feeds every event pin, pin order
    assign addr_detect = {src[5], 2'b00, src[2:0]};
    assign rcv_reg_read = src[3];
    assign xmt_reg_write = src[4];
    assign data_detect = src[6];
    assign {clock_mode_strap_3, clock_mode_strap_2, clock_mode_strap_1} = ckm;
    rsd_top uut (.*);
    rsd_board u_board (.por_req, .hard_req, .soft_req, .hard_out(hard_reset_n_out), .hard_oe(hard_reset_n_oe),
        .soft_out(soft_reset_n_out), .soft_oe(soft_reset_n_oe), .ev_ext, .ev_out(event_pin_out),
        .ev_oe(event_pin_oe), .por_n(power_on_reset_n), .hard_n(hard_reset_n_in), .soft_n(soft_reset_n_in),
        .ev_in(event_pin_in));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // apb cycle; request held until pready is seen high, answer taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask : cycles
    task automatic run_wait;
        for (int i = 0; i < 60 && reset_state !== RSD_RUN; i++)
            @(posedge pclk);
        chk("state run", reset_state, RSD_RUN);
    endtask : run_wait
    // power-on with straps held through release, sync needs them steady
    task automatic por(input logic h, input logic [2:0] c, input logic [1:0] bm, input logic dbg);
        @(posedge pclk);
        host_port_boot_strap <= h;
        ckm <= c;
        boot_mode_strap <= bm;
        debug_entry_strap <= dbg;
        por_req <= 1'b1;
        cycles(8);
        chk("state por", reset_state, RSD_POR);
        por_req <= 1'b0;
    endtask : por
    task automatic rst(input logic p, input logic h, input logic s, input rsd_state_e e);
        @(posedge pclk);
        {por_req, hard_req, soft_req} <= {p, h, s};
        cycles(6);
        chk("state held", reset_state, e);
        {por_req, hard_req, soft_req} <= 3'b000;
        run_wait();
    endtask : rst
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // clock and hang guard
    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            complete_run();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, src, ev_ext, debug_ack} = '0;
        {hard_req, soft_req, reset_cfg_select, ref_clock_in, delay_loop_feedback_in} = '0;
        {host_port_boot_strap, debug_entry_strap, boot_mode_strap, ckm} = '0;
        {own_xfer_valid, own_xfer_code, own_bank} = '0;
        por_req = 1'b1;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        por(1'b0, 3'b101, 2'b10, 1'b1);
        run_wait();
        chk("boot", boot_select, 2'b10);
        chk("clock mode", clock_mode, 3'b101);
        chk("debug entry", debug_mode_entry, 1'b1);
        chk("host port", host_port_enable, 1'b0);
        apb(1'b0, `RSD_OFS_EVDIR, 32'h0);
        chk("evdir reset", rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped data", rd, 32'h0);
        chk("unmapped err", err, 1'b1);
        $display("test straps done");
        apb(1'b1, `RSD_OFS_EVDIR, 32'h7f);
        cycles(1);
        chk("oe", event_pin_oe, 7'h7f);
        for (int i = 0; i < 7; i++)
        begin
            src <= 7'h01 << i;
            cycles(2);
            chk("event out", event_pin_out, 7'h01 << i);
        end
        src <= 7'h00;
        apb(1'b1, `RSD_OFS_EVSEL, 32'h2);
        debug_ack <= 1'b1;
        cycles(2);
        chk("ack pin", event_pin_out[1], 1'b1);
        debug_ack <= 1'b0;
        apb(1'b1, `RSD_OFS_EVSEL, 32'h0);
        apb(1'b1, `RSD_OFS_EVDIR, 32'h0);
        ev_ext <= 7'h64;
        cycles(4);
        chk("data enable", data_chan_enable, 1'b1);
        chk("chan5 enable", addr_chan_enable[5], 1'b1);
        apb(1'b0, `RSD_OFS_EVIN, 32'h0);
        chk("evin", rd, 32'h64);
        apb(1'b1, `RSD_OFS_EVSEL, 32'h4);
        cycles(1);
        chk("pin in fns", {event_gen, event_counter_enable, debug_request}, 3'b110);
        $display("test events done");
        apb(1'b1, `RSD_OFS_CONTROL, 32'h3);
        own_bank <= 3'b110;
        cycles(3);
        chk("bank", {sdram_bank_sel_2, sdram_bank_sel_1, sdram_bank_sel_0}, 3'b110);
        b = ~bus_clock_out;
        cycles(1);
        chk("bus clock", bus_clock_out, b);
        apb(1'b1, `RSD_OFS_CONTROL, 32'h0);
        own_xfer_valid <= 1'b1;
        own_xfer_code <= 3'b101;
        cycles(3);
        chk("xfer code", {xfer_code_2, xfer_code_1, xfer_code_0}, 3'b101);
        chk("bus clock off", bus_clock_out, 1'b0);
        $display("test bus pins done");
        rst(1'b0, 1'b1, 1'b0, RSD_HARD);
        rst(1'b0, 1'b0, 1'b1, RSD_SOFT);
        rst(1'b0, 1'b1, 1'b1, RSD_HARD);
        rst(1'b1, 1'b1, 1'b1, RSD_POR);
        apb(1'b1, `RSD_OFS_CONTROL, 32'h200);
        for (int i = 0; i < 12 && reset_state !== RSD_HARD; i++)
            @(posedge pclk);
        chk("sw hard", reset_state, RSD_HARD);
        run_wait();
        $display("test resets done");
        por(1'b1, 3'b000, 2'b01, 1'b0);
        cycles(20);
        chk("host wait", reset_state == RSD_RUN, 1'b0);
        chk("host en", {host_port_enable, bus_32bit}, 2'b11);
        apb(1'b1, `RSD_OFS_CONTROL, 32'h100);
        run_wait();
        $display("test host boot done");
        complete_run();
    end
endmodule : tb
